// File: ccp_control_pins.sv
// Overview of operation
// RULE1: Output transmits when software gate bit or gate pin is high.
// RULE2: Gate bit and pin both low disables output, forcing midscale codes.
// RULE3: Chip reset pin low returns programming registers to defaults.
// RULE4: Serial select is an active-low input, never driven.
// RULE5: Serial data line is two-way in 3-pin mode, input in 4-pin.
// RULE6: Serial output line floats in 3-pin mode, drives reads in 4-pin.
// RULE7: Output strobe pair sampled on rising clock edge for multi-chip sync.
// RULE8: Sleep pin high forces power-down at once, without a clock.
// RULE9: With sleep high at power-up, host writes fuse bit after init step. No fuse bit or init step is modelled here.
// RULE10: Gate pin is synchronised before combining with the software bit.
`timescale 1ns/10ps
`default_nettype none
module ccp_control_pins (
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        chip_reset_pin_n_i,
   input  wire logic        tx_gate_pin_i,
   input  wire logic        sleep_pin_i,
   input  wire logic        ctrl_wr_i,
   input  wire logic [15:0] ctrl_wdata_i,
   input  wire logic [15:0] chan_i_data_i,
   input  wire logic [15:0] chan_q_data_i,
   input  wire logic        serial_select_n_i,
   input  wire logic        four_pin_mode_i,
   input  wire logic        serial_io_i,
   input  wire logic        rd_active_i,
   input  wire logic        rd_bit_i,
   input  wire logic        output_strobe_pos_i,
   input  wire logic        output_strobe_neg_i,
   output logic [15:0]      output_control_word_o,
   output logic             tx_enable_o,
   output logic [15:0]      dac_i_code_o,
   output logic [15:0]      dac_q_code_o,
   output logic             power_down_o,
   output logic             serial_in_o,
   output logic             serial_io_o,
   output logic             serial_io_oe_n_o,
   output logic             serial_out_line_o,
   output logic             serial_out_line_oe_n_o,
   output logic             strobe_level_o,
   output logic             strobe_pulse_o
);
   logic        prog_rst_n;
   logic        tx_pin_sync;
   logic        gate_on;
   logic [15:0] ctrl_r;
   logic [15:0] ctrl_nxt;
   logic        tx_en_r;
   logic        tx_en_nxt;
   logic [15:0] i_code_r;
   logic [15:0] i_code_nxt;
   logic [15:0] q_code_r;
   logic [15:0] q_code_nxt;
   logic        pd_r;
   logic        pd_nxt;
   logic        sin_r;
   logic        sin_nxt;
   logic        sio_r;
   logic        sio_nxt;
   logic        sio_oe_n_r;
   logic        sio_oe_n_nxt;
   logic        sout_r;
   logic        sout_nxt;
   logic        sout_oe_n_r;
   logic        sout_oe_n_nxt;
   logic        strb_r;
   logic        strb_nxt;
   logic        strb_pls_r;
   logic        strb_pls_nxt;

   // Reset pin clears programming state
   assign prog_rst_n = reset_n_i & chip_reset_pin_n_i;

   // RULE10: pin synchroniser
   ccp_sync2 u_tx_sync (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .async_i    (tx_gate_pin_i),
      .sync_o     (tx_pin_sync)
   );

   // RULE1: OR of gate sources
   assign gate_on = ctrl_r[ccp_pkg::TXGATE_BIT] | tx_pin_sync;

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (ctrl_wr_i) begin
         ctrl_nxt = ctrl_wdata_i;
      end
      tx_en_nxt = gate_on;
      // RULE2: midscale when gated off
      i_code_nxt = gate_on ? chan_i_data_i : ccp_pkg::MIDSCALE_CODE;
      q_code_nxt = gate_on ? chan_q_data_i : ccp_pkg::MIDSCALE_CODE;
      pd_nxt = 1'b0;
   end

   // RULE3: defaults under chip reset
   always_ff @(posedge core_clk_i or negedge prog_rst_n) begin
      if (!prog_rst_n) begin
         ctrl_r <= ccp_pkg::OUT_CTRL_RESET;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_en_r  <= 1'b0;
         i_code_r <= ccp_pkg::MIDSCALE_CODE;
         q_code_r <= ccp_pkg::MIDSCALE_CODE;
      end else begin
         tx_en_r  <= tx_en_nxt;
         i_code_r <= i_code_nxt;
         q_code_r <= q_code_nxt;
      end
   end

   // RULE8: asynchronous power-down set
   always_ff @(posedge core_clk_i or negedge reset_n_i
               or posedge sleep_pin_i) begin
      if (sleep_pin_i) begin
         pd_r <= 1'b1;
      end else if (!reset_n_i) begin
         pd_r <= 1'b0;
      end else begin
         pd_r <= pd_nxt;
      end
   end

   always_comb begin
      // RULE4: select only ever read
      sin_nxt = !serial_select_n_i ? serial_io_i : 1'b0;
      sio_nxt = rd_bit_i;
      sout_nxt = rd_bit_i;
      // RULE5: two-way only in 3-pin mode
      sio_oe_n_nxt = !((four_pin_mode_i == ccp_pkg::THREE_PIN_MODE)
                       && !serial_select_n_i && rd_active_i);
      // RULE6: dedicated line only in 4-pin mode
      sout_oe_n_nxt = !((four_pin_mode_i == ccp_pkg::FOUR_PIN_MODE)
                        && !serial_select_n_i && rd_active_i);
      // RULE7: strobe capture and edge
      strb_nxt = output_strobe_pos_i & ~output_strobe_neg_i;
      strb_pls_nxt = strb_nxt & ~strb_r;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sin_r       <= 1'b0;
         sio_r       <= 1'b0;
         sio_oe_n_r  <= 1'b1;
         sout_r      <= 1'b0;
         sout_oe_n_r <= 1'b1;
         strb_r      <= 1'b0;
         strb_pls_r  <= 1'b0;
      end else begin
         sin_r       <= sin_nxt;
         sio_r       <= sio_nxt;
         sio_oe_n_r  <= sio_oe_n_nxt;
         sout_r      <= sout_nxt;
         sout_oe_n_r <= sout_oe_n_nxt;
         strb_r      <= strb_nxt;
         strb_pls_r  <= strb_pls_nxt;
      end
   end

   assign output_control_word_o  = ctrl_r;
   assign tx_enable_o            = tx_en_r;
   assign dac_i_code_o           = i_code_r;
   assign dac_q_code_o           = q_code_r;
   assign power_down_o           = pd_r;
   assign serial_in_o            = sin_r;
   assign serial_io_o            = sio_r;
   assign serial_io_oe_n_o       = sio_oe_n_r;
   assign serial_out_line_o      = sout_r;
   assign serial_out_line_oe_n_o = sout_oe_n_r;
   assign strobe_level_o         = strb_r;
   assign strobe_pulse_o         = strb_pls_r;

   sequence s_pin_rise;
      $rose(tx_gate_pin_i) ##1 tx_gate_pin_i;
   endsequence

   sequence s_strobe_edge;
      !strb_r ##1 strb_r;
   endsequence

   property p_sw_gate;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      ctrl_r[ccp_pkg::TXGATE_BIT] |=> tx_enable_o;
   endproperty
   a_sw_gate: assert property (p_sw_gate) // RULE1
      else $error("software gate did not enable output");

   property p_gate_off_mid;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (!ctrl_r[ccp_pkg::TXGATE_BIT] && !tx_pin_sync) |=>
         (!tx_enable_o && dac_i_code_o == ccp_pkg::MIDSCALE_CODE
          && dac_q_code_o == ccp_pkg::MIDSCALE_CODE);
   endproperty
   a_gate_off_mid: assert property (p_gate_off_mid) // RULE2
      else $error("disabled output not at midscale");

   property p_chip_reset;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      !chip_reset_pin_n_i |-> output_control_word_o == ccp_pkg::OUT_CTRL_RESET;
   endproperty
   a_chip_reset: assert property (p_chip_reset) // RULE3
      else $error("control word not at default under chip reset");

   property p_sel_idle;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      serial_select_n_i |=> (serial_io_oe_n_o && serial_out_line_oe_n_o
                             && !serial_in_o);
   endproperty
   a_sel_idle: assert property (p_sel_idle) // RULE4
      else $error("serial pins active while deselected");

   property p_three_pin;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      (!four_pin_mode_i && !serial_select_n_i && rd_active_i)
         |=> (!serial_io_oe_n_o && serial_io_o == $past(rd_bit_i));
   endproperty
   a_three_pin: assert property (p_three_pin) // RULE5
      else $error("data line not driving in 3-pin read");

   property p_sdo_float;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      !four_pin_mode_i |=> serial_out_line_oe_n_o;
   endproperty
   a_sdo_float: assert property (p_sdo_float) // RULE6
      else $error("output line driven in 3-pin mode");

   property p_strobe;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      s_strobe_edge |-> strobe_pulse_o ##1 !strobe_pulse_o;
   endproperty
   a_strobe: assert property (p_strobe) // RULE7
      else $error("strobe edge pulse wrong");

   property p_sleep;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      sleep_pin_i |-> power_down_o;
   endproperty
   a_sleep: assert property (p_sleep) // RULE8
      else $error("sleep did not force power-down");

   property p_pin_sync;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      s_pin_rise ##0 (tx_gate_pin_i [*2]) |=> tx_enable_o;
   endproperty
   a_pin_sync: assert property (p_pin_sync) // RULE10
      else $error("gate pin not seen after synchroniser delay");
endmodule // ccp_control_pins
`default_nettype wire

// File: ccp_pkg.sv
package ccp_pkg;
   localparam int          WORD_W          = 16;
   localparam int          TXGATE_BIT      = 0;
   localparam logic [15:0] OUT_CTRL_RESET  = 16'h0000;
   localparam logic [15:0] MIDSCALE_CODE   = 16'h8000;
   localparam int          SYNC_STAGES     = 2;
   localparam logic        THREE_PIN_MODE  = 1'b0;
   localparam logic        FOUR_PIN_MODE   = 1'b1;
endpackage : ccp_pkg

// File: ccp_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module ccp_sync2 (
   input  wire logic core_clk_i,
   input  wire logic reset_n_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_r;
   logic meta_nxt;
   logic sync_r;
   logic sync_nxt;

   always_comb begin
      meta_nxt = async_i;
      sync_nxt = meta_r;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_o = sync_r;
endmodule // ccp_sync2
`default_nettype wire

// File: ccp_host.sv
`timescale 1ns/10ps
`default_nettype none
module ccp_host (
   input  wire logic  core_clk_i,
   input  wire logic  dev_sio_i,
   input  wire logic  dev_sio_oe_n_i,
   output logic        chip_reset_n_o,
   output logic        tx_gate_o,
   output logic        sleep_o,
   output logic        wr_o,
   output logic [15:0] wdata_o,
   output logic        select_n_o,
   output logic        sio_o
);
   logic host_en;
   logic host_val;
   assign sio_o = !dev_sio_oe_n_i ? dev_sio_i : (host_en ? host_val : 1'b0);
   initial begin
      {chip_reset_n_o, select_n_o} = 2'h3;
      {tx_gate_o, sleep_o, wr_o, host_en, host_val} = 5'h00;
      wdata_o = 16'h0000;
   end
   task automatic write_word(input logic [15:0] d);
      @(posedge core_clk_i);
      wr_o    <= 1'b1;
      wdata_o <= d;
      @(posedge core_clk_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;
   endtask
   task automatic pins(input logic rn, input logic g, input logic s,
                       input logic sel_n, input logic en, input logic v);
      @(posedge core_clk_i);
      chip_reset_n_o <= rn;
      tx_gate_o      <= g;
      sleep_o        <= s;
      select_n_o     <= sel_n;
      host_en        <= en;
      host_val       <= v;
   endtask
endmodule // ccp_host
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, four = 1'b0, rda = 1'b0, rdb = 1'b0;
   logic spos = 1'b0, sneg = 1'b1;
   logic [15:0] ci = 16'h1234, cq = 16'h4321;
   int check_count = 0, mismatches = 0;
   wire logic crn, gate, slp, wr, sel_n, sio, sio_o, sio_oe_n, txe, pd;
   wire logic sin, sol, sol_oe_n, slev, spul;
   wire logic [15:0] wd, word, di, dq;
   always #50 clk = ~clk;
   ccp_host host (.core_clk_i(clk), .dev_sio_i(sio_o),
      .dev_sio_oe_n_i(sio_oe_n), .chip_reset_n_o(crn), .tx_gate_o(gate),
      .sleep_o(slp), .wr_o(wr), .wdata_o(wd), .select_n_o(sel_n),
      .sio_o(sio));
   ccp_control_pins uut (.core_clk_i(clk), .reset_n_i(rst_n),
      .chip_reset_pin_n_i(crn), .tx_gate_pin_i(gate), .sleep_pin_i(slp),
      .ctrl_wr_i(wr), .ctrl_wdata_i(wd), .chan_i_data_i(ci),
      .chan_q_data_i(cq), .serial_select_n_i(sel_n), .four_pin_mode_i(four),
      .serial_io_i(sio), .rd_active_i(rda), .rd_bit_i(rdb),
      .output_strobe_pos_i(spos), .output_strobe_neg_i(sneg),
      .output_control_word_o(word), .tx_enable_o(txe), .dac_i_code_o(di),
      .dac_q_code_o(dq), .power_down_o(pd), .serial_in_o(sin),
      .serial_io_o(sio_o), .serial_io_oe_n_o(sio_oe_n),
      .serial_out_line_o(sol), .serial_out_line_oe_n_o(sol_oe_n),
      .strobe_level_o(slev), .strobe_pulse_o(spul));
   task automatic edges(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic t_reset();
      `CHK("word", 16'h0000, word)
      `CHK("txe", 1'b0, txe)
      `CHK("i code", 16'h8000, di)
      `CHK("oe_n", 2'h3, {sio_oe_n, sol_oe_n})
      $display("test reset done");
   endtask
   task automatic t_sw_gate();
      host.write_word(16'h0001);
      #1 `CHK("word", 16'h0001, word)
      edges(1); `CHK("txe", 1'b1, txe)
      edges(1); `CHK("codes", {ci, cq}, {di, dq})
      host.write_word(16'h0000);
      edges(2); `CHK("codes", 32'h80008000, {di, dq})
      $display("test software gate done");
   endtask
   task automatic t_pin_gate();
      host.pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      edges(2); `CHK("txe early", 1'b0, txe)
      edges(1); `CHK("txe", 1'b1, txe)
      host.pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      edges(4); `CHK("codes", 32'h80008000, {di, dq})
      $display("test pin gate done");
   endtask
   task automatic t_chip_reset();
      host.write_word(16'hA5A1);
      #1 `CHK("word", 16'hA5A1, word)
      host.pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      #1 `CHK("word async", 16'h0000, word)
      host.pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      $display("test chip reset done");
   endtask
   task automatic t_sleep();
      host.pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      #1 `CHK("pd async", 1'b1, pd)
      host.pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      edges(2); `CHK("pd off", 1'b0, pd)
      $display("test sleep done");
   endtask
   task automatic t_serial();
      host.pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      four <= 1'b0;
      rda <= 1'b1;
      rdb <= 1'b1;
      edges(1);
      `CHK("3pin", 3'h3, {sio_oe_n, sio_o, sol_oe_n})
      `CHK("3pin sol", 1'b1, sol_oe_n)
      host.pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      four <= 1'b1;
      edges(1); `CHK("4pin", 3'h5, {sio_oe_n, sol_oe_n, sol})
      `CHK("sin", 1'b1, sin)
      host.pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      edges(1); `CHK("deselect", 3'h6, {sio_oe_n, sol_oe_n, sin})
      $display("test serial done");
   endtask
   task automatic t_strobe();
      @(posedge clk);
      spos <= 1'b1;
      sneg <= 1'b0;
      edges(1);
      `CHK("level", 1'b1, slev)
      `CHK("pulse", 1'b1, spul)
      edges(1);
      `CHK("pulse end", 1'b0, spul)
      $display("test strobe done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      edges(1);
      t_reset();
      t_sw_gate();
      t_pin_gate();
      t_chip_reset();
      t_sleep();
      t_serial();
      t_strobe();
      test_done();
   end
   initial begin
      #(300 * 100);
      mismatches++;
      test_done();
   end
endmodule // testbench
`default_nettype wire
